// ---- design/snv_defs.vh ----
// Constants for the serial nonvolatile SRAM command slave.
// Included by the protection decode and the slave, not the synchroniser; definitions only.
`ifndef SNV_DEFS_VH
`define SNV_DEFS_VH

// Opcodes
`define SNV_OP_SET_WL 8'h06
`define SNV_OP_CLR_WL 8'h04
`define SNV_OP_STAT_RD 8'h05
`define SNV_OP_STAT_WR 8'h01
`define SNV_OP_MEM_RD 8'h03
`define SNV_OP_MEM_WR 8'h02
`define SNV_OP_STORE 8'h3C
`define SNV_OP_RECALL 8'h60
`define SNV_OP_AS_ON 8'h59
`define SNV_OP_AS_OFF 8'h19

// Status byte field positions
`define SNV_SR_BUSY 0
`define SNV_SR_WEL 1
`define SNV_SR_BP_LO 2
`define SNV_SR_BP_HI 3
`define SNV_SR_ARM 7

// Status reset value and address constants
`define SNV_SR_RESET 8'h00
`define SNV_ADDR_W 17
`define SNV_ADDR_LAST 17'h1_FFFF
`define SNV_PROT_QTR 17'h1_8000
`define SNV_PROT_HALF 17'h1_0000

`endif

// ---- design/snv_prot.v ----
// Block protection decode: flags an address inside the protected range.
// Assumes 17-bit byte addresses and the two level bits from status.
`timescale 1ns/10ps
`include "snv_defs.vh"
module snv_prot (
   // Level and address
   input wire [1:0] level,
   input wire [16:0] addr,
   // Result
   output reg protected_hit
);
   always @* begin
      case (level)
         2'b01: protected_hit = (addr >= `SNV_PROT_QTR);
         2'b10: protected_hit = (addr >= `SNV_PROT_HALF);
         2'b11: protected_hit = 1'b1;
         default: protected_hit = 1'b0;
      endcase
   end
endmodule // snv_prot

// ---- design/snv_slave.v ----
// Serial command slave of a byte-wide nonvolatile SRAM.
// Assumes an SPI master in mode 0 or 3; sck, cs_n, si, protect pin are
// asynchronous and are sampled by clk_sys, which must run well above sck.
// The array itself sits outside, reached by a one-cycle write strobe and
// a read address whose data must be valid the next clk_sys cycle.
//
// Summary of operation
// - Status write, memory write, special commands need the latch set.
// - The write-enable latch is cleared at reset.
// - Write commands with latch clear are ignored until chip select rises.
// - Set-latch opcode sets the write-enable latch.
// - Status write, memory write, special commands clear the latch at end.
// - Clear-latch opcode clears the latch at chip select rising edge.
// - Level bits protect none, top quarter, top half or the whole array.
// - Protected locations stay readable but are never written.
// - Level bits are written by status write, returned by status read.
// - Protect pin low with arming bit set blocks status writes.
// - Arming bit clear makes the protect pin irrelevant.
// - Protect pin falling mid-frame does not abort a status write.
// - Read sends opcode then three address bytes, A16 in bit 0.
// - Read data leaves on falling sck edges, D7 first.
// - Serial input is ignored after the last read address bit.
// - Read bursts auto-increment and wrap from top to zero.
// - Write sends opcode, three address bytes, then data MSB first.
// - Write bursts store at incremented addresses, wrapping to zero.
// - Bursts skip storage in protected space but keep incrementing.
// - Decode latch set, latch clear, status read, status write opcodes.
// - Decode memory read and memory write opcodes.
// - All fields MSB first; commands start at chip select falling.
// - Busy status bit reads 1 while store or recall runs.
`timescale 1ns/10ps
`include "snv_defs.vh"
module snv_slave (
   // Clock and reset
   input wire clk_sys,
   input wire sys_rst,
   // Serial link pins
   input wire sck,
   input wire cs_n,
   input wire si,
   output reg so,
   output wire so_oe,
   // Protect pin, active low
   input wire protect_n,
   // Store or recall cycle running, from the nonvolatile engine
   input wire nv_busy,
   // Array port
   output reg [16:0] mem_addr,
   output reg [7:0] mem_wdata,
   output reg mem_we,
   input wire [7:0] mem_rdata,
   // Special command pulses to the nonvolatile engine
   output reg store_req,
   output reg recall_req,
   output reg autosave_on_req,
   output reg autosave_off_req,
   // Status view
   output wire [7:0] status_byte
);
   localparam ST_CMD = 6'b00_0001;
   localparam ST_ADDR = 6'b00_0010;
   localparam ST_RDAT = 6'b00_0100;
   localparam ST_WDAT = 6'b00_1000;
   localparam ST_SWR = 6'b01_0000;
   localparam ST_IDLE = 6'b10_0000;

   wire sck_s;
   wire cs_n_s;
   wire si_s;
   wire prot_n_s;
   reg sck_d_reg;
   reg cs_d_reg;
   reg [5:0] state_reg;
   reg [2:0] bit_reg;
   reg [7:0] shift_reg;
   reg [1:0] abyte_reg;
   reg [7:0] op_reg;
   reg [16:0] addr_reg;
   reg [7:0] dout_reg;
   reg wel_reg;
   reg [1:0] level_reg;
   reg arm_reg;
   reg [2:0] spare_reg;
   reg wel_clr_reg;
   reg load_pend_reg;
   reg sr_ok_reg;
   wire sck_rise;
   wire sck_fall;
   wire cs_fall;
   wire cs_rise;
   wire [7:0] byte_in;
   wire byte_done;
   wire hit;

   snv_sync #(.RST_VAL(1'b0)) u_sck (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .din(sck), .dout(sck_s));
   snv_sync #(.RST_VAL(1'b1)) u_cs (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .din(cs_n), .dout(cs_n_s));
   snv_sync #(.RST_VAL(1'b0)) u_si (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .din(si), .dout(si_s));
   snv_sync #(.RST_VAL(1'b1)) u_wp (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .din(protect_n), .dout(prot_n_s));

   snv_prot u_prot (.level(level_reg), .addr(addr_reg),
      .protected_hit(hit));

   assign sck_rise = sck_s & ~sck_d_reg & ~cs_n_s;
   assign sck_fall = ~sck_s & sck_d_reg & ~cs_n_s;
   assign cs_fall = ~cs_n_s & cs_d_reg;
   assign cs_rise = cs_n_s & ~cs_d_reg;
   assign byte_in = {shift_reg[6:0], si_s};
   assign byte_done = sck_rise & (bit_reg == 3'd7);
   assign so_oe = ~cs_n_s;
   assign status_byte = {arm_reg, spare_reg, level_reg, wel_reg, nv_busy};

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         sck_d_reg <= 1'b0;
         cs_d_reg <= 1'b1;
      end else begin
         sck_d_reg <= sck_s;
         cs_d_reg <= cs_n_s;
      end
   end

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
         bit_reg <= 3'd0;
         shift_reg <= 8'h00;
         abyte_reg <= 2'd0;
         op_reg <= 8'h00;
         addr_reg <= 17'h0_0000;
         dout_reg <= 8'h00;
         so <= 1'b0;
         wel_reg <= 1'b0;
         level_reg <= 2'b00;
         arm_reg <= 1'b0;
         spare_reg <= 3'b000;
         wel_clr_reg <= 1'b0;
         load_pend_reg <= 1'b0;
         sr_ok_reg <= 1'b0;
         mem_addr <= 17'h0_0000;
         mem_wdata <= 8'h00;
         mem_we <= 1'b0;
         store_req <= 1'b0;
         recall_req <= 1'b0;
         autosave_on_req <= 1'b0;
         autosave_off_req <= 1'b0;
      end else begin
         mem_we <= 1'b0;
         store_req <= 1'b0;
         recall_req <= 1'b0;
         autosave_on_req <= 1'b0;
         autosave_off_req <= 1'b0;
         load_pend_reg <= 1'b0;
         if (sck_rise) begin
            shift_reg <= byte_in;
            bit_reg <= bit_reg + 3'd1;
         end
         // Array data is one cycle behind the address
         if (load_pend_reg) begin
            dout_reg <= mem_rdata;
            mem_addr <= (addr_reg == `SNV_ADDR_LAST) ? 17'h0_0000
               : addr_reg + 17'h0_0001;
         end
         if (cs_fall) begin
            state_reg <= ST_CMD;
            bit_reg <= 3'd0;
            abyte_reg <= 2'd0;
         end else if (cs_rise) begin
            state_reg <= ST_IDLE;
            if (wel_clr_reg)
               wel_reg <= 1'b0;
            wel_clr_reg <= 1'b0;
            case (op_reg)
               `SNV_OP_STORE: store_req <= 1'b1;
               `SNV_OP_RECALL: recall_req <= 1'b1;
               `SNV_OP_AS_ON: autosave_on_req <= 1'b1;
               `SNV_OP_AS_OFF: autosave_off_req <= 1'b1;
               default: ;
            endcase
            op_reg <= 8'h00;
         end else begin
            case (state_reg)
               ST_CMD: begin
                  if (byte_done) begin
                     case (byte_in)
                        `SNV_OP_SET_WL: begin
                           wel_reg <= 1'b1;
                           state_reg <= ST_IDLE;
                        end
                        `SNV_OP_CLR_WL: begin
                           wel_clr_reg <= 1'b1;
                           state_reg <= ST_IDLE;
                        end
                        `SNV_OP_STAT_RD: begin
                           dout_reg <= status_byte;
                           so <= status_byte[7];
                           state_reg <= ST_RDAT;
                        end
                        `SNV_OP_MEM_RD: state_reg <= ST_ADDR;
                        `SNV_OP_STAT_WR, `SNV_OP_MEM_WR,
                        `SNV_OP_STORE, `SNV_OP_RECALL,
                        `SNV_OP_AS_ON, `SNV_OP_AS_OFF: begin
                           if (wel_reg) begin
                              op_reg <= byte_in;
                              wel_clr_reg <= 1'b1;
                              if (byte_in == `SNV_OP_STAT_WR) begin
                                 sr_ok_reg <= ~(arm_reg & ~prot_n_s);
                                 state_reg <= ST_SWR;
                              end else if (byte_in == `SNV_OP_MEM_WR)
                                 state_reg <= ST_ADDR;
                              else
                                 state_reg <= ST_IDLE;
                           end else
                              state_reg <= ST_IDLE;
                        end
                        default: state_reg <= ST_IDLE;
                     endcase
                     if (byte_in == `SNV_OP_MEM_RD)
                        op_reg <= byte_in;
                  end
               end
               ST_ADDR: begin
                  if (byte_done) begin
                     abyte_reg <= abyte_reg + 2'd1;
                     // A16 from bit 0 of first byte
                     case (abyte_reg)
                        2'd0: addr_reg[16] <= byte_in[0];
                        2'd1: addr_reg[15:8] <= byte_in;
                        default: addr_reg[7:0] <= byte_in;
                     endcase
                     if (abyte_reg == 2'd2) begin
                        if (op_reg == `SNV_OP_MEM_RD) begin
                           mem_addr <= {addr_reg[16:8], byte_in};
                           load_pend_reg <= 1'b1;
                           state_reg <= ST_RDAT;
                        end else
                           state_reg <= ST_WDAT;
                     end
                  end
               end
               ST_RDAT: begin
                  // Shift out on falling sck, si ignored
                  if (sck_fall) begin
                     if (bit_reg == 3'd0) begin
                        so <= dout_reg[7];
                     end else
                        so <= dout_reg[3'd7 - bit_reg];
                  end
                  if (byte_done && op_reg == `SNV_OP_MEM_RD) begin
                     addr_reg <= mem_addr;
                     load_pend_reg <= 1'b1;
                  end
               end
               ST_WDAT: begin
                  if (byte_done) begin
                     mem_we <= ~hit;
                     mem_addr <= addr_reg;
                     mem_wdata <= byte_in;
                     addr_reg <= (addr_reg == `SNV_ADDR_LAST)
                        ? 17'h0_0000 : addr_reg + 17'h0_0001;
                  end
               end
               ST_SWR: begin
                  if (byte_done) begin
                     // Level, arm and spare bits written
                     if (sr_ok_reg) begin
                        arm_reg <= byte_in[`SNV_SR_ARM];
                        spare_reg <= byte_in[6:4];
                        level_reg <= byte_in[`SNV_SR_BP_HI:`SNV_SR_BP_LO];
                     end
                     state_reg <= ST_IDLE;
                  end
               end
               ST_IDLE: ;
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end
endmodule // snv_slave

// ---- design/snv_sync.v ----
// Two flip-flop synchroniser for one pin level.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/10ps
module snv_sync #(
   parameter RST_VAL = 1'b0
) (
   // Clock and reset
   input wire clk_sys,
   input wire sys_rst,
   // Level in and out
   input wire din,
   output reg dout
);
   reg meta_reg;
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         meta_reg <= RST_VAL;
         dout <= RST_VAL;
      end else begin
         meta_reg <= din;
         dout <= meta_reg;
      end
   end
endmodule // snv_sync

// ---- sim/snv_slave_asserts.sv ----
// Checker of the serial SRAM slave ports.
// Assumes one clk_sys domain; bound onto snv_slave.
`timescale 1ns/10ps
module snv_slave_chk (
   // Clock and reset
   input wire clk_sys,
   input wire sys_rst,
   // Link and pins
   input wire sck,
   input wire cs_n,
   input wire si,
   input wire so,
   input wire so_oe,
   input wire protect_n,
   input wire nv_busy,
   // Array, requests, status
   input wire [16:0] mem_addr,
   input wire [7:0] mem_wdata,
   input wire mem_we,
   input wire [7:0] mem_rdata,
   input wire store_req,
   input wire recall_req,
   input wire autosave_on_req,
   input wire autosave_off_req,
   input wire [7:0] status_byte
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   wire wel = status_byte[1];
   wire [1:0] lv = status_byte[3:2];
   wire req = store_req | recall_req | autosave_on_req | autosave_off_req;
   wire hit = lv == 2'h3 || (lv == 2'h2 && mem_addr >= 17'h1_0000) ||
      (lv == 2'h1 && mem_addr >= 17'h1_8000);
   a_rst_clear:
   assert property ($past(sys_rst) |-> status_byte[7:1] == 7'h00)
      else $error("status not clear after reset");
   a_busy_bit:
   assert property (status_byte[0] == nv_busy)
      else $error("busy bit differs from engine");
   a_we_framed:
   assert property (mem_we |-> so_oe)
      else $error("array write outside a frame");
   a_we_wel:
   assert property (mem_we |-> wel)
      else $error("array write with latch clear");
   a_we_unprot:
   assert property (mem_we |-> !hit)
      else $error("array write in protected range");
   a_we_spacing:
   assert property (mem_we |=> !mem_we [*8])
      else $error("array write strobe too long");
   a_wel_frame:
   assert property ($changed(wel) |-> $past(so_oe) || $past(so_oe, 2))
      else $error("latch moved away from a frame");
   a_stat_wel:
   assert property ($changed(status_byte[7:2]) |-> $past(wel) || $past(wel, 2))
      else $error("status written with latch clear");
   a_req_wel:
   assert property (req |-> $past(wel) || $past(wel, 2))
      else $error("special request with latch clear");
   cover property (mem_we && mem_addr == 17'h0_0000);
   cover property (req);
   cover property ($fell(wel));
endmodule // snv_slave_chk

bind snv_slave snv_slave_chk chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
   .protect_n(protect_n), .nv_busy(nv_busy), .mem_addr(mem_addr),
   .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata),
   .store_req(store_req), .recall_req(recall_req),
   .autosave_on_req(autosave_on_req),
   .autosave_off_req(autosave_off_req), .status_byte(status_byte));

// ---- sim/snv_slave_tb_top.sv ----
// Testbench of the serial SRAM slave with an array model.
// Assumes the host model and the bound checker.
`timescale 1ns/10ps
module snv_slave_tb_top;
   reg clk_sys = 1'b0;
   reg sys_rst = 1'b1;
   reg protect_n = 1'b1;
   reg nv_busy = 1'b0;
   wire [7:0] mem_rdata;
   wire sck, cs_n, si, so, so_oe, mem_we;
   wire store_req, recall_req, autosave_on_req, autosave_off_req;
   wire [16:0] mem_addr;
   wire [7:0] mem_wdata, status_byte;
   reg [7:0] mem_arr [0:131071];
   reg [3:0] req_seen = 4'h0;
   reg [3:0] rq = 4'h0;
   reg [7:0] rx, op;
   reg [16:0] a, b;
   integer error_cnt = 0, checks = 0, cyc = 0, l, p, k;
   always #10 clk_sys = ~clk_sys;
   snv_slave dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .sck(sck),
      .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
      .protect_n(protect_n), .nv_busy(nv_busy), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata),
      .store_req(store_req), .recall_req(recall_req),
      .autosave_on_req(autosave_on_req),
      .autosave_off_req(autosave_off_req), .status_byte(status_byte));
   snv_spi_host host_u (.clk_sys(clk_sys), .sck(sck), .cs_n(cs_n),
      .si(si), .so(so));
   // Array read is combinational; the slave takes it one cycle later
   assign mem_rdata = mem_arr[mem_addr];
   always @(posedge clk_sys) begin
      if (mem_we) mem_arr[mem_addr] <= mem_wdata;
      req_seen <= req_seen |
         {store_req, recall_req, autosave_on_req, autosave_off_req};
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         error_cnt = error_cnt + 1;
         complete_run;
      end
   end
   function blk(input integer lv, input [16:0] ad);
      blk = lv == 3 || (lv == 2 && ad >= 17'h1_0000) ||
         (lv == 1 && ad >= 17'h1_8000);
   endfunction
   task chk(input [8*8-1:0] nm, input [16:0] exp, input [16:0] got); begin
      checks = checks + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("BAD %0s expected %h seen %h", nm, exp, got);
      end
   end endtask
   task frame1(input [7:0] c); begin
      host_u.sel;
      host_u.xfer(c, rx);
      host_u.desel;
   end endtask
   // Spare bits of the top address byte set: they must not matter
   task cmd(input [7:0] c, input [16:0] ad); begin
      host_u.sel;
      host_u.xfer(c, rx);
      host_u.xfer({7'h7F, ad[16]}, rx);
      host_u.xfer(ad[15:8], rx);
      host_u.xfer(ad[7:0], rx);
   end endtask
   task stat_rd(input [7:0] exp); begin
      host_u.sel;
      host_u.xfer(8'h05, rx);
      host_u.xfer(8'hA5, rx);
      chk("so_oe", 1'b1, so_oe);
      host_u.desel;
      chk("so_off", 1'b0, so_oe);
      chk("status", exp, rx);
      chk("stat_pin", exp, status_byte);
   end endtask
   // Status write carries one data byte right after the opcode
   task stat_wr(input [7:0] d); begin
      frame1(8'h06);
      host_u.sel;
      host_u.xfer(8'h01, rx);
      host_u.xfer(d, rx);
      host_u.desel;
   end endtask
   task complete_run; begin
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   end endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      stat_rd(8'h00);
      mem_arr[16] = 8'h11;
      // Engine stays idle around every memory command
      cmd(8'h02, 17'h0_0010);
      host_u.xfer(8'hAA, rx);
      host_u.desel;
      chk("nolatch", 8'h11, mem_arr[16]);
      frame1(8'h06);
      stat_rd(8'h02);
      frame1(8'h04);
      stat_rd(8'h00);
      $display("test latch done");
      frame1(8'h06);
      cmd(8'h02, 17'h1_FFFF);
      host_u.xfer(8'hA1, rx);
      host_u.xfer(8'hA2, rx);
      host_u.desel;
      chk("wr_top", 8'hA1, mem_arr[17'h1_FFFF]);
      chk("wr_wrap", 8'hA2, mem_arr[0]);
      stat_rd(8'h00);
      mem_arr[17'h1_FFFE] = 8'h5A;
      cmd(8'h03, 17'h1_FFFE);
      host_u.xfer(8'h96, rx);
      chk("rd0", 8'h5A, rx);
      host_u.xfer(8'h69, rx);
      chk("rd1", 8'hA1, rx);
      host_u.xfer(8'h96, rx);
      chk("rd_wrap", 8'hA2, rx);
      host_u.desel;
      $display("test burst done");
      for (l = 0; l < 4; l = l + 1) begin
         stat_wr({4'h0, l[1:0], 2'h0});
         stat_rd({4'h0, l[1:0], 2'h0});
         for (p = 0; p < 3; p = p + 1) begin
            a = p == 0 ? 17'h0_FFFF : p == 1 ? 17'h1_7FFF : 17'h1_FFFF;
            b = a + 17'h0_0001;
            mem_arr[a] = 8'hEE;
            mem_arr[b] = 8'hEE;
            frame1(8'h06);
            cmd(8'h02, a);
            host_u.xfer(8'h31, rx);
            host_u.xfer(8'h32, rx);
            host_u.desel;
            chk("lvl_a", blk(l, a) ? 8'hEE : 8'h31, mem_arr[a]);
            chk("lvl_b", blk(l, b) ? 8'hEE : 8'h32, mem_arr[b]);
         end
      end
      $display("test levels done");
      stat_wr(8'h80);
      protect_n <= 1'b0;
      stat_wr(8'h84);
      stat_rd(8'h80);
      protect_n <= 1'b1;
      stat_wr(8'h00);
      protect_n <= 1'b0;
      stat_wr(8'h88);
      stat_rd(8'h88);
      protect_n <= 1'b1;
      frame1(8'h06);
      host_u.sel;
      host_u.xfer(8'h01, rx);
      protect_n <= 1'b0;
      host_u.xfer(8'h00, rx);
      host_u.desel;
      stat_rd(8'h00);
      protect_n <= 1'b1;
      $display("test pin done");
      for (k = 0; k < 4; k = k + 1) begin
         op = k == 0 ? 8'h3C : k == 1 ? 8'h60 : k == 2 ? 8'h59 : 8'h19;
         frame1(op);
         chk("req_off", rq, req_seen);
         frame1(8'h06);
         frame1(op);
         rq = rq | (4'h8 >> k);
         chk("req_on", rq, req_seen);
         stat_rd(8'h00);
      end
      nv_busy <= 1'b1;
      stat_rd(8'h01);
      nv_busy <= 1'b0;
      $display("test special done");
      complete_run;
   end
endmodule // snv_slave_tb_top

// ---- sim/snv_spi_host.sv ----
// Mode 0 serial master model, stepped on clk_sys.
// Assumes the slave samples sck with clk_sys; half period is HALF clocks.
`timescale 1ns/10ps
module snv_spi_host #(
   parameter HALF = 4
) (
   // Clock
   input wire clk_sys,
   // Link toward the slave
   output reg sck = 1'b0,
   output reg cs_n = 1'b1,
   output reg si = 1'b0,
   // Link from the slave
   input wire so
);
   // Idle data toggles so a stale level never passes for data
   always @(posedge clk_sys) begin
      if (cs_n) begin
         si <= ~si;
      end
   end
   task sel; begin
      @(posedge clk_sys);
      cs_n <= 1'b0;
      repeat (HALF) @(posedge clk_sys);
   end endtask
   task desel; begin
      repeat (HALF) @(posedge clk_sys);
      cs_n <= 1'b1;
      repeat (4 * HALF) @(posedge clk_sys);
   end endtask
   // MSB first, set while low, taken at rise
   task xfer(input [7:0] tx, output [7:0] rx);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            si <= tx[i];
            repeat (HALF) @(posedge clk_sys);
            rx[i] = so;
            sck <= 1'b1;
            repeat (HALF) @(posedge clk_sys);
            sck <= 1'b0;
         end
      end
   endtask
endmodule // snv_spi_host
